// ==== ext_int_pkg.sv ====
// Constants for the external interrupt detect and timer gate block
package ext_int_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TCTL = 8'h88;
  localparam logic [7:0] IDX_TIMER_MODE_CONTROL = 8'h89;
  localparam logic [7:0] IDX_ICFG = 8'h90;
  localparam logic [7:0] IDX_ISTS = 8'h91;
  localparam logic [7:0] IDX_ICLR = 8'h92;
  localparam logic [7:0] IDX_IEN = 8'h93;
  localparam int IDX_SHIFT = 2;
  // timer_and_ext_int_control fields
  localparam int TCTL_A_EDGE = 0;
  localparam int TCTL_A_PEND = 1;
  localparam int TCTL_B_EDGE = 2;
  localparam int TCTL_B_PEND = 3;
  localparam int TCTL_HI_LSB = 4;
  localparam int TCTL_HI_W = 4;
  localparam int TCTL_B_RUN = 6;
  // timer_mode_control fields
  localparam int TIMER_MODE_CONTROL_B_GATE = 7;
  // ext_irq_config_reg fields
  localparam int ICFG_A_POL = 0;
  localparam int ICFG_B_POL = 1;
  // Interrupt status bits
  localparam int IRQ_N = 2;
  localparam int IRQ_A_BIT = 0;
  localparam int IRQ_B_BIT = 1;
  // Reset values
  localparam logic [7:0] TCTL_RST = 8'h00;
  localparam logic [7:0] TIMER_MODE_CONTROL_RST = 8'h00;
  localparam logic [7:0] ICFG_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;
endpackage

// ==== ext_int_detect_timer_gate.sv ====
// External interrupt detection, pending flags and timer 1 gating
// How it works
// - Input b: type bit 0 level, 1 edge
// - Input b polarity from config register bit
// - Input a: type bit 0 level, 1 edge
// - Input a polarity from config register bit
// - Gate bit 0: timer runs on run bit
// - Gate bit 1: run bit and b active
// - Run bit enables, clearing it stops timer
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
module ext_int_detect_timer_gate
  import ext_int_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  output logic [DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ext_irq_a_input_i,
  input wire logic ext_irq_b_input_i,
  input wire logic ext_irq_a_ack_i,
  input wire logic ext_irq_b_ack_i,
  output logic ext_irq_a_pending_o,
  output logic ext_irq_b_pending_o,
  output logic tmr_b_count_en_o,
  output logic irq_o
);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] prev_active;
  logic [1:0] pending;
  logic [1:0] edge_sel;
  logic [TCTL_HI_W-1:0] tctl_hi;
  logic [REG_W-1:0] timer_mode_control;
  logic [REG_W-1:0] ext_irq_config_reg;
  logic [IRQ_N-1:0] irq_status;
  logic [IRQ_N-1:0] irq_enable;
  logic [DATA_W-1:0] rdata;
  logic err;

  // Sync flops reset to the inactive pin level, so no false onset follows
  localparam logic [1:0] SYNC_IDLE = ~{ICFG_RST[ICFG_B_POL],
                                       ICFG_RST[ICFG_A_POL]};

  wire setup = psel_i && !penable_i;
  wire access = psel_i && penable_i;
  wire wr = access && pwrite_i;
  wire hit_tctl = hit(paddr_i, IDX_TCTL);
  wire hit_timer_mode_control = hit(paddr_i, IDX_TIMER_MODE_CONTROL);
  wire hit_icfg = hit(paddr_i, IDX_ICFG);
  wire hit_ists = hit(paddr_i, IDX_ISTS);
  wire hit_iclr = hit(paddr_i, IDX_ICLR);
  wire hit_ien = hit(paddr_i, IDX_IEN);
  wire mapped = hit_tctl | hit_timer_mode_control | hit_icfg | hit_ists |
                hit_iclr | hit_ien;
  wire wr_tctl = wr && hit_tctl;

  wire [REG_W-1:0] timer_and_ext_int_control = {tctl_hi,
    pending[IRQ_B_BIT], edge_sel[IRQ_B_BIT],
    pending[IRQ_A_BIT], edge_sel[IRQ_A_BIT]};

  wire [1:0] polarity = {ext_irq_config_reg[ICFG_B_POL],
                         ext_irq_config_reg[ICFG_A_POL]};
  wire [1:0] wr_edge = {pwdata_i[TCTL_B_EDGE], pwdata_i[TCTL_A_EDGE]};
  wire [1:0] wr_pend = {pwdata_i[TCTL_B_PEND], pwdata_i[TCTL_A_PEND]};
  wire [1:0] ack = {ext_irq_b_ack_i, ext_irq_a_ack_i};

  logic [1:0] active;
  logic [1:0] set_evt;
  logic [1:0] next_pending;

  genvar i;
  generate
    for (i = 0; i < IRQ_N; i++) begin : g_ch
      // Polarity 1 means active high
      assign active[i] = polarity[i] ? sync2[i] : !sync2[i];
      // Level mode follows the input, edge mode catches onset
      assign set_evt[i] = edge_sel[i] ?
        (active[i] && !prev_active[i]) : active[i];
      // Set wins over software clear and vector clear
      assign next_pending[i] = set_evt[i] ||
        (wr_tctl ? wr_pend[i] :
         (pending[i] && !(edge_sel[i] && ack[i])));
    end
  endgenerate

  wire b_gate = timer_mode_control[TIMER_MODE_CONTROL_B_GATE];
  wire b_run = tctl_hi[TCTL_B_RUN-TCTL_HI_LSB];
  assign tmr_b_count_en_o = b_run &&
    (!b_gate || active[IRQ_B_BIT]);

  // Status set beats a write-one-clear in the same cycle
  wire [IRQ_N-1:0] clr_bits = (wr && hit_iclr) ?
    pwdata_i[IRQ_N-1:0] : IRQ_RST;
  wire [IRQ_N-1:0] next_status = set_evt | (irq_status & ~clr_bits);

  always_comb begin
    rdata = '0;
    if (hit_tctl) begin
      rdata[REG_W-1:0] = timer_and_ext_int_control;
    end else if (hit_timer_mode_control) begin
      rdata[REG_W-1:0] = timer_mode_control;
    end else if (hit_icfg) begin
      rdata[REG_W-1:0] = ext_irq_config_reg;
    end else if (hit_ists) begin
      rdata[IRQ_N-1:0] = irq_status;
    end else if (hit_ien) begin
      rdata[IRQ_N-1:0] = irq_enable;
    end
  end

  // Two flops before any logic sees the pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
      prev_active <= 2'h0;
    end else begin
      sync1 <= {ext_irq_b_input_i, ext_irq_a_input_i};
      sync2 <= sync1;
      prev_active <= active;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending <= TCTL_RST[1:0];
      edge_sel <= TCTL_RST[1:0];
      tctl_hi <= TCTL_RST[REG_W-1:TCTL_HI_LSB];
    end else begin
      pending <= next_pending;
      if (wr_tctl) begin
        edge_sel <= wr_edge;
        tctl_hi <= pwdata_i[REG_W-1:TCTL_HI_LSB];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_mode_control <= TIMER_MODE_CONTROL_RST;
      ext_irq_config_reg <= ICFG_RST;
      irq_enable <= IRQ_RST;
      irq_status <= IRQ_RST;
    end else begin
      irq_status <= next_status;
      if (wr && hit_timer_mode_control) begin
        timer_mode_control <= pwdata_i[REG_W-1:0];
      end
      if (wr && hit_icfg) begin
        ext_irq_config_reg <= pwdata_i[REG_W-1:0];
      end
      if (wr && hit_ien) begin
        irq_enable <= pwdata_i[IRQ_N-1:0];
      end
    end
  end

  // Read data captured in setup so the answer comes from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= '0;
      err <= 1'b0;
    end else if (setup) begin
      prdata_o <= pwrite_i ? '0 : rdata;
      err <= !mapped;
    end
  end

  assign pready_o = access;
  assign pslverr_o = access && err;
  assign ext_irq_a_pending_o = pending[IRQ_A_BIT];
  assign ext_irq_b_pending_o = pending[IRQ_B_BIT];
  assign irq_o = |(irq_status & irq_enable);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence b_edge_onset;
    edge_sel[IRQ_B_BIT] && active[IRQ_B_BIT] && !prev_active[IRQ_B_BIT];
  endsequence

  sequence a_edge_onset;
    edge_sel[IRQ_A_BIT] && active[IRQ_A_BIT] && !prev_active[IRQ_A_BIT];
  endsequence

  b_edge_sets_a: assert property (b_edge_onset |=> pending[IRQ_B_BIT])
    else $error("edge on input b did not set pending");

  b_level_follow_a: assert property (
    !edge_sel[IRQ_B_BIT] && active[IRQ_B_BIT] && !wr_tctl
    |=> pending[IRQ_B_BIT])
    else $error("level on input b did not hold pending");

  b_polarity_a: assert property (
    sync2[IRQ_B_BIT] == polarity[IRQ_B_BIT]
    |-> active[IRQ_B_BIT])
    else $error("input b polarity not applied");

  a_edge_sets_a: assert property (a_edge_onset |=> pending[IRQ_A_BIT])
    else $error("edge on input a did not set pending");

  a_no_retrigger_a: assert property (
    edge_sel[IRQ_A_BIT] && !pending[IRQ_A_BIT] && !wr_tctl
    && prev_active[IRQ_A_BIT]
    ##1 !pending[IRQ_A_BIT] && prev_active[IRQ_A_BIT]
    |-> !set_evt[IRQ_A_BIT])
    else $error("input a edge mode set on steady level");

  a_polarity_a: assert property (
    $rose(sync2[IRQ_A_BIT]) && polarity[IRQ_A_BIT]
    && $stable(polarity[IRQ_A_BIT]) |-> active[IRQ_A_BIT])
    else $error("input a polarity not applied");

  gate_off_run_a: assert property (
    !b_gate && b_run |-> tmr_b_count_en_o)
    else $error("timer b not running with gate off");

  gate_on_block_a: assert property (
    b_gate && !active[IRQ_B_BIT] |-> !tmr_b_count_en_o)
    else $error("timer b ran while gate input inactive");

  run_stop_a: assert property (
    wr_tctl && !pwdata_i[TCTL_B_RUN] |=> !tmr_b_count_en_o)
    else $error("timer b kept running after run cleared");

  edge_ack_clr_a: assert property (
    edge_sel[IRQ_A_BIT] && ext_irq_a_ack_i && !wr_tctl
    && !set_evt[IRQ_A_BIT] |=> !pending[IRQ_A_BIT])
    else $error("vector did not clear edge pending a");

  irq_out_a: assert property (
    (b_edge_onset and (irq_enable[IRQ_B_BIT] && !(wr && hit_ien)))
    |=> irq_o [*1])
    else $error("enabled event did not raise irq");

  // Level mode without a type change keeps pending set
  sequence a_level_hold;
    !edge_sel[IRQ_A_BIT] && active[IRQ_A_BIT] && !wr_tctl;
  endsequence

  // Unmapped address seen in the setup cycle
  sequence unmapped_setup;
    setup && !mapped;
  endsequence

  a_level_follow_a: assert property (
    a_level_hold |=> pending[IRQ_A_BIT])
    else $error("level on input a did not hold pending");

  a_low_active_a: assert property (
    !edge_sel[IRQ_A_BIT] && !polarity[IRQ_A_BIT] && !sync2[IRQ_A_BIT]
    && !wr_tctl |=> pending[IRQ_A_BIT])
    else $error("low level on input a did not set pending");

  b_steady_quiet_a: assert property (
    edge_sel[IRQ_B_BIT] && !pending[IRQ_B_BIT] && !set_evt[IRQ_B_BIT]
    && !wr_tctl |=> !pending[IRQ_B_BIT])
    else $error("input b edge mode set without onset");

  a_edge_hold_a: assert property (
    edge_sel[IRQ_A_BIT] && pending[IRQ_A_BIT] && !ext_irq_a_ack_i
    && !wr_tctl |=> pending[IRQ_A_BIT])
    else $error("edge pending a dropped without clear");

  b_ack_clr_a: assert property (
    edge_sel[IRQ_B_BIT] && ext_irq_b_ack_i && !wr_tctl
    && !set_evt[IRQ_B_BIT] |=> !pending[IRQ_B_BIT])
    else $error("vector did not clear edge pending b");

  level_ack_keep_a: assert property (
    !edge_sel[IRQ_A_BIT] && pending[IRQ_A_BIT] && ext_irq_a_ack_i
    && !wr_tctl |=> pending[IRQ_A_BIT])
    else $error("vector cleared level pending a");

  sw_clear_a: assert property (
    wr_tctl && !wr_pend[IRQ_A_BIT] && !set_evt[IRQ_A_BIT]
    |=> !pending[IRQ_A_BIT])
    else $error("software write did not clear pending a");

  status_set_a: assert property (
    set_evt[IRQ_B_BIT] |=> irq_status[IRQ_B_BIT])
    else $error("event on input b did not set status");

  gate_on_pass_a: assert property (
    b_gate && b_run && active[IRQ_B_BIT] |-> tmr_b_count_en_o)
    else $error("timer b stopped while gate input active");

  b_gate_polarity_a: assert property (
    b_gate && b_run && sync2[IRQ_B_BIT] == polarity[IRQ_B_BIT]
    |-> tmr_b_count_en_o)
    else $error("gate ignored input b polarity");

  run_off_a: assert property (
    !b_run |-> !tmr_b_count_en_o)
    else $error("timer b ran with run bit clear");

  unmapped_err_a: assert property (
    unmapped_setup ##1 access |-> pslverr_o)
    else $error("unmapped access gave no error");

endmodule

// ==== pin_driver.sv ====
// Board-side model of the two external interrupt pins
`timescale 1ns/1ns
module pin_driver (
  input wire logic clk_i,
  input wire logic [1:0] lvl_i,
  output logic ext_irq_a_input_o = 1'b1,
  output logic ext_irq_b_input_o = 1'b1
);
  // Board logic settles after the edge, like a registered driver
  always @(posedge clk_i) begin
    ext_irq_a_input_o <= lvl_i[0];
    ext_irq_b_input_o <= lvl_i[1];
  end
endmodule

// ==== ext_int_detect_timer_gate_bench.sv ====
// Self-checking bench for the interrupt detect and timer gate block
`timescale 1ns/1ns
module ext_int_detect_timer_gate_bench;
  import ext_int_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, pa, pb, pend_a, pend_b, cnt_en, irq;
  logic [1:0] lvl = 2'b11, ack = 0;
  logic [32:0] q[$];
  logic [6:0] rnd;
  int n_mismatch = 0, checks = 0, seed = 86;
  always #5 clk = ~clk;
  pin_driver pin_driver_i (.clk_i(clk), .lvl_i(lvl),
    .ext_irq_a_input_o(pa), .ext_irq_b_input_o(pb));
  ext_int_detect_timer_gate ext_int_detect_timer_gate_i (.clk_i(clk),
    .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .ext_irq_a_input_i(pa),
    .ext_irq_b_input_i(pb), .ext_irq_a_ack_i(ack[0]),
    .ext_irq_b_ack_i(ack[1]), .ext_irq_a_pending_o(pend_a),
    .ext_irq_b_pending_o(pend_b), .tmr_b_count_en_o(cnt_en), .irq_o(irq));
  task results();
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task cmp(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e);
    q.push_back(e);
    xfer(0, a, 0);
  endtask
  task pins(input logic [1:0] v);
    @(posedge clk);
    lvl <= v;
  endtask
  // Outputs as {irq, count enable, pending b, pending a}
  task see(input logic [3:0] e);
    repeat (6) @(posedge clk);
    #1;
    cmp({29'h0, irq, cnt_en, pend_b, pend_a}, {29'h0, e});
  endtask
  // Read data is judged where the slave answers
  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp({pslverr, prdata}, q.pop_front());
  initial begin
    #50000;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    rd(12'h220, 0);
    rd(12'h224, 0);
    rd(12'h240, 0);
    xfer(1, 12'h24c, 32'h0000_0003);
    see(4'b0000);
    pins(2'b00);
    see(4'b1011);
    pins(2'b11);
    see(4'b1011);
    rd(12'h244, 3);
    xfer(1, 12'h248, 32'h0000_0003);
    see(4'b0011);
    xfer(1, 12'h240, 32'h0000_0003);
    see(4'b1011);
    pins(2'b00);
    see(4'b1011);
    xfer(1, 12'h220, 32'h0000_0005);
    xfer(1, 12'h248, 32'h0000_0003);
    see(4'b0000);
    rd(12'h220, 5);
    pins(2'b11);
    see(4'b1011);
    pins(2'b00);
    see(4'b1011);
    @(posedge clk);
    ack <= 2'b01;
    @(posedge clk);
    ack <= 2'b00;
    see(4'b1010);
    xfer(1, 12'h220, 32'h0000_0005);
    see(4'b1000);
    xfer(1, 12'h248, 32'h0000_0003);
    rnd = 7'($random(seed));
    xfer(1, 12'h224, {24'h0, 1'b0, rnd});
    rd(12'h224, {26'h0, rnd});
    xfer(1, 12'h220, 32'h0000_0045);
    see(4'b0100);
    xfer(1, 12'h224, {24'h0, 1'b1, rnd});
    see(4'b0000);
    pins(2'b10);
    see(4'b1110);
    @(posedge clk);
    ack <= 2'b10;
    @(posedge clk);
    ack <= 2'b00;
    see(4'b1100);
    xfer(1, 12'h220, 32'h0000_0005);
    see(4'b1000);
    xfer(1, 12'h24c, 32'h0000_0000);
    see(4'b0000);
    rd(12'h300, 33'h1_0000_0000);
    // Let the read monitor judge the last answer first
    @(posedge clk);
    results();
  end
endmodule
